// File: design/tci_byte_order.sv
// Byte ordering of fetched words for data written to tape
// Assumes one word in per cycle on fetch_valid
`timescale 1ns/100ps
`include "tci_params.svh"
module tci_byte_order (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        swap,
	input  wire logic        in_valid,
	input  wire logic [15:0] in_word,
	output logic             out_valid,
	output logic [15:0]      out_word
);
	// Swap set gives the even byte first; clear gives the odd byte first
	always_ff @(posedge clk) begin
		if (srst) begin
			out_valid <= 1'b0;
			out_word  <= 16'h0000;
		end else begin
			out_valid <= in_valid;
			if (in_valid) begin
				out_word <= swap ? {in_word[7:0], in_word[15:8]} : in_word;
			end
		end
	end
endmodule

// File: design/tci_counter.sv
// Record and mark counter for position commands
// Assumes load and step never fall in the same cycle
`timescale 1ns/100ps
module tci_counter (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        load,
	input  wire logic [15:0] value,
	input  wire logic        step,
	output logic [15:0]      count,
	output logic             zero
);
	always_ff @(posedge clk) begin
		if (srst) begin
			count <= 16'h0000;
		end else if (load) begin
			count <= value;
		end else if (step && count != 16'h0000) begin
			count <= count - 16'h0001;
		end
	end
	assign zero = (count == 16'h0000);
endmodule

// File: design/tci_params.svh
// Constants for the tape command interpreter: field positions, codes, bits
// Assumes inclusion by tci_byte_order and tci_top by bare name
`ifndef TCI_PARAMS_SVH
`define TCI_PARAMS_SVH
// Register offsets on the plain register port
`define TCI_REG_CHAR        4'h0
`define TCI_REG_CMD_HDR     4'h1
`define TCI_REG_CMD_W2      4'h2
`define TCI_REG_CMD_W3      4'h3
`define TCI_REG_CMD_W4      4'h4
`define TCI_REG_GO          4'h5
`define TCI_REG_STATUS      4'h6
`define TCI_REG_EXTENDED_STATUS_0        4'h7
`define TCI_REG_EXTENDED_STATUS_3        4'h8
`define TCI_REG_RESIDUAL    4'h9
`define TCI_REG_ADDR_LO     4'ha
`define TCI_REG_ADDR_HI     4'hb
`define TCI_REG_MSGLEN      4'hc
// Characteristics mode byte bits
`define TCI_CH_DMS          7
`define TCI_CH_OSM          6
`define TCI_CH_ATTENTION_MESSAGE         5
`define TCI_CH_BREL         4
// Header word fields
`define TCI_HDR_SWAP        12
`define TCI_HDR_IRQ         7
`define TCI_HDR_MODE_HI     11
`define TCI_HDR_MODE_LO     8
`define TCI_HDR_CMD_HI      4
`define TCI_HDR_CMD_LO      0
// Command codes
`define TCI_CMD_WRITE       5'h05
`define TCI_CMD_POSITION    5'h08
`define TCI_CMD_FORMAT      5'h09
`define TCI_CMD_CONTROL     5'h0a
// Mode codes
`define TCI_MODE_0          4'h0
`define TCI_MODE_1          4'h1
`define TCI_MODE_2          4'h2
`define TCI_MODE_3          4'h3
`define TCI_MODE_4          4'h4
// Extended status bit positions
`define TCI_X0_EOT          0
`define TCI_X0_NEF          10
`define TCI_X0_LEADTM       13
`define TCI_X0_RLS          14
`define TCI_X3_RIB          0
`define TCI_X3_DCK          3
// Termination classes
`define TCI_TC_NORMAL       3'h0
`define TCI_TC_ALERT        3'h2
`define TCI_TC_REJECT       3'h3
`define TCI_TC_POSLOST      3'h6
// Erase length and message buffer minimum
`define TCI_ERASE_MILS      16'd3750
`define TCI_MSGLEN_MIN      16'd14
`endif

// File: design/tci_pkg.sv
// Types for the tape command interpreter
// Assumes the params header sits beside it
package tci_pkg;
	// Motion request to the tape drive sequencer
	typedef enum logic [2:0] {
		TCI_MV_NONE,
		TCI_MV_SPACE_FWD,
		TCI_MV_SPACE_REV,
		TCI_MV_WRITE,
		TCI_MV_ERASE,
		TCI_MV_MARK,
		TCI_MV_REWIND
	} tci_motion_e;
	typedef struct packed {
		tci_motion_e op;
		logic        go;
	} tci_motion_s;
	// Drive events reported back for one motion
	typedef struct packed {
		logic done;
		logic record;
		logic mark;
		logic at_start;
		logic at_end;
	} tci_drive_s;
	// Memory fetch request for write data
	typedef struct packed {
		logic        req;
		logic [21:0] addr;
	} tci_fetch_s;
endpackage

// File: design/tci_top.sv
// Tape command interpreter: write, position and format commands, characteristics
// Assumes a drive sequencer answering each motion request with one done pulse
// Operation
// - Double-mark and off-start stop: leading tape mark stops skip, sets bit 13.
// - Attention disabled: no attention message; next command is rejected.
// - Attention enabled: message when buffer owned; irq only if last irq flag.
// - Buffer release: ready flag reasserted; irq too when release irq enabled.
// - Write mode 0 writes data; mode 2 spaces reverse, erases, writes.
// - Write byte count is word four; zero means 65536 bytes.
// - Write at or past end marker ends with alert; end bit held.
// - Bad identification burst: write or format sets density check, position lost.
// - Fetched write bytes ordered by the header swap flag.
// - Upper address bits 21..18 used only with 22-bit addressing.
// - Position modes: space fwd, rev, skip fwd, rev, rewind ignoring count.
// - Space records counts tape mark; ends with alert on a mark.
// - Space or skip ending with count nonzero sets record-length-short bit.
// - Skip marks stops on two adjacent marks when double-mark stop set.
// - Reverse space or skip meeting start marker sets reverse-into-start, alert class.
// - Reverse or mark retry at start: non-executable bit, reject, no motion.
// - Position with density error sets bit, still moves, ends with alert.
// - Rewind completion interrupt waits until start marker reached and stopped.
// - Format modes: 0 tape mark, 1 erase, 2 space reverse, erase, mark.
// - Format at or past end marker: alert class, end bit set and held.
// - Erase and mark each erase a fixed 3.75 inch length.
`timescale 1ns/100ps
`include "tci_params.svh"
module tci_top
	import tci_pkg::*;
(
	input  wire logic                 MCLK,
	input  wire logic                 SRST,
	input  wire logic [3:0]           REG_ADDR,
	input  wire logic [15:0]          REG_WDATA,
	input  wire logic                 REG_WR,
	input  wire logic                 REG_RD,
	output logic [15:0]               REG_RDATA,
	input  wire logic                 ADDR22_EN,
	input  wire logic                 ATTENTION_MESSAGE_EVENT,
	input  wire logic                 ID_BURST_BAD,
	input  wire tci_pkg::tci_drive_s  DRIVE,
	output tci_pkg::tci_motion_s      MOTION,
	output logic [15:0]               ERASE_MILS,
	output tci_pkg::tci_fetch_s       FETCH,
	input  wire logic                 FETCH_VALID,
	input  wire logic [15:0]          FETCH_DATA,
	output logic                      WDATA_VALID,
	output logic [15:0]               WDATA,
	output logic [16:0]               WRITE_BYTES,
	output logic                      ATTENTION_MESSAGE_MSG,
	output logic                      IRQ
);
	import tci_pkg::*;

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [7:0]  char_mode;
	logic [15:0] msg_addr_lo, msg_addr_hi, msg_len;
	logic [15:0] hdr, w2, w3, w4;
	logic [15:0] extended_status_0, extended_status_3;
	logic [2:0]  term_class;
	logic        ready, last_irq_en, attention_message_pending, reject_next, buf_owned;
	logic [15:0] residual;
	logic        go;

	typedef enum logic [2:0] {
		S_IDLE, S_REV, S_ERASE, S_DO, S_SKIP, S_REWIND, S_END
	} tci_state_e;
	tci_state_e state;

	logic [4:0]  cmd;
	logic [3:0]  mode;
	logic        cnt_load, cnt_step, cnt_zero;
	logic [15:0] cnt;
	logic        prev_mark, first_rec, pos_op, pos_rev, is_skip, rel_irq;

	assign cmd  = hdr[`TCI_HDR_CMD_HI:`TCI_HDR_CMD_LO];
	assign mode = hdr[`TCI_HDR_MODE_HI:`TCI_HDR_MODE_LO];
	assign go   = REG_WR && REG_ADDR == `TCI_REG_GO && ready;

	function automatic logic is_cmd(input logic [4:0] c, input logic [3:0] m, input logic [4:0] wc,
		input logic [3:0] wm);
		is_cmd = (c == wc) && (m == wm);
	endfunction

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			char_mode   <= 8'h00;
			msg_addr_lo <= 16'h0000;
			msg_addr_hi <= 16'h0000;
			msg_len     <= 16'h0000;
			hdr         <= 16'h0000;
			w2          <= 16'h0000;
			w3          <= 16'h0000;
			w4          <= 16'h0000;
		end else if (REG_WR && ready) begin
			unique case (REG_ADDR)
				`TCI_REG_CHAR:    char_mode   <= REG_WDATA[7:0];
				`TCI_REG_CMD_HDR: hdr         <= REG_WDATA;
				`TCI_REG_CMD_W2:  w2          <= REG_WDATA;
				`TCI_REG_CMD_W3:  w3          <= REG_WDATA;
				`TCI_REG_CMD_W4:  w4          <= REG_WDATA;
				`TCI_REG_ADDR_LO: msg_addr_lo <= REG_WDATA;
				`TCI_REG_ADDR_HI: msg_addr_hi <= REG_WDATA;
				`TCI_REG_MSGLEN:  msg_len     <= REG_WDATA;
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Register read port
	// ****************************************************************
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			REG_RDATA <= 16'h0000;
		end else if (REG_RD) begin
			unique case (REG_ADDR)
				`TCI_REG_CHAR:     REG_RDATA <= {8'h00, char_mode};
				`TCI_REG_CMD_HDR:  REG_RDATA <= hdr;
				`TCI_REG_CMD_W2:   REG_RDATA <= w2;
				`TCI_REG_CMD_W3:   REG_RDATA <= w3;
				`TCI_REG_CMD_W4:   REG_RDATA <= w4;
				`TCI_REG_STATUS:   REG_RDATA <= {8'h00, ready, buf_owned, reject_next, attention_message_pending, 1'b0,
					term_class};
				`TCI_REG_EXTENDED_STATUS_0:     REG_RDATA <= extended_status_0;
				`TCI_REG_EXTENDED_STATUS_3:     REG_RDATA <= extended_status_3;
				`TCI_REG_RESIDUAL: REG_RDATA <= residual;
				`TCI_REG_ADDR_LO:  REG_RDATA <= msg_addr_lo;
				`TCI_REG_ADDR_HI:  REG_RDATA <= msg_addr_hi;
				`TCI_REG_MSGLEN:   REG_RDATA <= msg_len;
				default:           REG_RDATA <= 16'h0000;
			endcase
		end else begin
			REG_RDATA <= 16'h0000;
		end
	end

	// ****************************************************************
	// Counter and byte ordering
	// ****************************************************************
	tci_counter u_cnt (
		.clk   (MCLK),
		.srst  (SRST),
		.load  (cnt_load),
		.value (w2),
		.step  (cnt_step),
		.count (cnt),
		.zero  (cnt_zero)
	);

	tci_byte_order u_swap (
		.clk       (MCLK),
		.srst      (SRST),
		.swap      (hdr[`TCI_HDR_SWAP]),
		.in_valid  (FETCH_VALID),
		.in_word   (FETCH_DATA),
		.out_valid (WDATA_VALID),
		.out_word  (WDATA)
	);

	assign ERASE_MILS  = `TCI_ERASE_MILS;
	assign WRITE_BYTES = (w4 == 16'h0000) ? 17'h10000 : {1'b0, w4};
	assign is_skip     = pos_op && (mode == `TCI_MODE_2 || mode == `TCI_MODE_3);
	assign cnt_load    = go && cmd == `TCI_CMD_POSITION;
	assign cnt_step    = (state == S_SKIP) && DRIVE.done && (is_skip ? DRIVE.mark : DRIVE.record || DRIVE.mark);

	// ****************************************************************
	// Command sequencer
	// ****************************************************************
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			state      <= S_IDLE;
			MOTION     <= '0;
			FETCH      <= '0;
			term_class <= `TCI_TC_NORMAL;
			extended_status_0       <= 16'h0000;
			extended_status_3       <= 16'h0000;
			residual   <= 16'h0000;
			ready      <= 1'b1;
			last_irq_en <= 1'b0;
			pos_op     <= 1'b0;
			pos_rev    <= 1'b0;
			prev_mark  <= 1'b0;
			first_rec  <= 1'b0;
			rel_irq    <= 1'b0;
			reject_next <= 1'b0;
		end else begin
			MOTION.go <= 1'b0;
			FETCH.req <= 1'b0;
			rel_irq   <= 1'b0;
			if (ATTENTION_MESSAGE_EVENT && !char_mode[`TCI_CH_ATTENTION_MESSAGE]) begin
				reject_next <= 1'b1;
			end
			if (DRIVE.done && pos_rev && DRIVE.at_start) begin
				extended_status_0[`TCI_X0_EOT] <= 1'b0;
			end
			unique case (state)
				S_IDLE: if (go) begin
					ready       <= 1'b0;
					last_irq_en <= hdr[`TCI_HDR_IRQ];
					extended_status_0[`TCI_X0_NEF]    <= 1'b0;
					extended_status_0[`TCI_X0_RLS]    <= 1'b0;
					extended_status_0[`TCI_X0_LEADTM] <= 1'b0;
					extended_status_3[`TCI_X3_RIB]    <= 1'b0;
					pos_op    <= cmd == `TCI_CMD_POSITION;
					pos_rev   <= cmd == `TCI_CMD_POSITION && (mode == `TCI_MODE_1 || mode == `TCI_MODE_3);
					first_rec <= DRIVE.at_start;
					prev_mark <= 1'b0;
					term_class <= `TCI_TC_NORMAL;
					state      <= S_END;
					if (reject_next) begin
						reject_next <= ATTENTION_MESSAGE_EVENT && !char_mode[`TCI_CH_ATTENTION_MESSAGE];
						term_class  <= `TCI_TC_REJECT;
					end else if (is_cmd(cmd, mode, `TCI_CMD_CONTROL, `TCI_MODE_0)) begin
						rel_irq <= char_mode[`TCI_CH_BREL];
					end else if (cmd == `TCI_CMD_WRITE || cmd == `TCI_CMD_FORMAT) begin
						if (DRIVE.at_end) begin
							extended_status_0[`TCI_X0_EOT] <= 1'b1;
							term_class <= `TCI_TC_ALERT;
						end else if (ID_BURST_BAD) begin
							extended_status_3[`TCI_X3_DCK] <= 1'b1;
							term_class <= `TCI_TC_POSLOST;
						end else if (mode == `TCI_MODE_2 && DRIVE.at_start) begin
							extended_status_0[`TCI_X0_NEF] <= 1'b1;
							term_class <= `TCI_TC_REJECT;
						end else if (mode == `TCI_MODE_2) begin
							MOTION <= '{op: TCI_MV_SPACE_REV, go: 1'b1};
							state  <= S_REV;
						end else if (cmd == `TCI_CMD_WRITE && mode == `TCI_MODE_0) begin
							MOTION <= '{op: TCI_MV_WRITE, go: 1'b1};
							FETCH  <= '{req: 1'b1, addr: {ADDR22_EN ? w3[5:2] : 4'h0, w3[1:0], w2}};
							state  <= S_DO;
						end else if (cmd == `TCI_CMD_FORMAT && mode <= `TCI_MODE_1) begin
							MOTION <= '{op: mode == `TCI_MODE_1 ? TCI_MV_ERASE : TCI_MV_MARK, go: 1'b1};
							state  <= S_DO;
						end else begin
							term_class <= `TCI_TC_REJECT;
						end
					end else if (cmd == `TCI_CMD_POSITION) begin
						if (ID_BURST_BAD) begin
							extended_status_3[`TCI_X3_DCK] <= 1'b1;
						end
						if ((mode == `TCI_MODE_1 || mode == `TCI_MODE_3) && DRIVE.at_start) begin
							extended_status_0[`TCI_X0_NEF] <= 1'b1;
							term_class <= `TCI_TC_REJECT;
						end else if (mode == `TCI_MODE_4) begin
							MOTION <= '{op: TCI_MV_REWIND, go: 1'b1};
							state  <= S_REWIND;
						end else if (mode <= `TCI_MODE_3) begin
							MOTION <= '{op: mode[0] ? TCI_MV_SPACE_REV : TCI_MV_SPACE_FWD, go: 1'b1};
							state  <= S_SKIP;
						end else begin
							term_class <= `TCI_TC_REJECT;
						end
					end else begin
						term_class <= `TCI_TC_REJECT;
					end
				end
				S_REV: if (DRIVE.done) begin
					MOTION <= '{op: TCI_MV_ERASE, go: 1'b1};
					state  <= S_ERASE;
				end
				S_ERASE: if (DRIVE.done) begin
					MOTION <= '{op: cmd == `TCI_CMD_WRITE ? TCI_MV_WRITE : TCI_MV_MARK, go: 1'b1};
					if (cmd == `TCI_CMD_WRITE) begin
						FETCH <= '{req: 1'b1, addr: {ADDR22_EN ? w3[5:2] : 4'h0, w3[1:0], w2}};
					end
					state <= S_DO;
				end
				S_DO: if (DRIVE.done) begin
					state <= S_END;
				end
				S_REWIND: if (DRIVE.done && DRIVE.at_start) begin
					state <= S_END;
				end
				S_SKIP: if (DRIVE.done) begin
					prev_mark <= DRIVE.mark;
					first_rec <= 1'b0;
					if (pos_rev && DRIVE.at_start) begin
						extended_status_3[`TCI_X3_RIB] <= 1'b1;
						term_class <= `TCI_TC_ALERT;
						residual   <= cnt;
						if (!cnt_zero) begin
							extended_status_0[`TCI_X0_RLS] <= 1'b1;
						end
						state <= S_END;
					end else if (is_skip && DRIVE.mark && first_rec && !pos_rev
						&& char_mode[`TCI_CH_DMS] && char_mode[`TCI_CH_OSM]) begin
						extended_status_0[`TCI_X0_LEADTM] <= 1'b1;
						extended_status_0[`TCI_X0_RLS]    <= cnt != 16'h0001;
						residual <= cnt - 16'h0001;
						state    <= S_END;
					end else if (is_skip && DRIVE.mark && prev_mark && char_mode[`TCI_CH_DMS]) begin
						extended_status_0[`TCI_X0_RLS] <= cnt != 16'h0001;
						residual <= cnt - 16'h0001;
						state    <= S_END;
					end else if (!is_skip && DRIVE.mark) begin
						term_class <= `TCI_TC_ALERT;
						extended_status_0[`TCI_X0_RLS] <= cnt != 16'h0001;
						residual <= cnt - 16'h0001;
						state    <= S_END;
					end else if (cnt_step && cnt == 16'h0001) begin
						residual <= 16'h0000;
						state    <= S_END;
					end else if (cnt_zero) begin
						residual <= 16'h0000;
						state    <= S_END;
					end else begin
						MOTION <= '{op: MOTION.op, go: 1'b1};
					end
				end
				S_END: begin
					if (pos_op && extended_status_3[`TCI_X3_DCK] && term_class == `TCI_TC_NORMAL) begin
						term_class <= `TCI_TC_ALERT;
					end
					ready <= 1'b1;
					state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Attention and interrupt
	// ****************************************************************
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			attention_message_pending <= 1'b0;
			buf_owned    <= 1'b0;
			ATTENTION_MESSAGE_MSG     <= 1'b0;
			IRQ          <= 1'b0;
		end else begin
			if (go && is_cmd(cmd, mode, `TCI_CMD_CONTROL, `TCI_MODE_0)) begin
				buf_owned <= 1'b1;
			end else if (go) begin
				buf_owned <= 1'b0;
			end
			ATTENTION_MESSAGE_MSG <= attention_message_pending && buf_owned;
			if (ATTENTION_MESSAGE_EVENT && char_mode[`TCI_CH_ATTENTION_MESSAGE]) begin
				attention_message_pending <= 1'b1;
			end else if (attention_message_pending && buf_owned) begin
				attention_message_pending <= 1'b0;
			end
			IRQ <= (state == S_END && last_irq_en) || rel_irq || (attention_message_pending && buf_owned && last_irq_en);
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_rej_nomove;
		@(posedge MCLK) disable iff (SRST) (go && DRIVE.at_start && cmd == `TCI_CMD_POSITION && mode == `TCI_MODE_1
			&& !reject_next) |=> !MOTION.go && extended_status_0[`TCI_X0_NEF] && term_class == `TCI_TC_REJECT;
	endproperty
	a_rej_nomove: assert property (p_rej_nomove) else $error("reverse at start moved");

	property p_eot;
		@(posedge MCLK) disable iff (SRST) (go && DRIVE.at_end && cmd == `TCI_CMD_FORMAT && !reject_next)
			|=> extended_status_0[`TCI_X0_EOT] && term_class == `TCI_TC_ALERT && !MOTION.go;
	endproperty
	a_eot: assert property (p_eot) else $error("end marker not handled");

	property p_dck;
		@(posedge MCLK) disable iff (SRST) (go && ID_BURST_BAD && !DRIVE.at_end && cmd == `TCI_CMD_WRITE
			&& !reject_next) |=> extended_status_3[`TCI_X3_DCK] && term_class == `TCI_TC_POSLOST;
	endproperty
	a_dck: assert property (p_dck) else $error("density check missing");

	property p_rewind;
		@(posedge MCLK) disable iff (SRST) (state == S_REWIND && !(DRIVE.done && DRIVE.at_start)) |=> !IRQ;
	endproperty
	a_rewind: assert property (p_rewind) else $error("rewind irq early");

	property p_count;
		@(posedge MCLK) disable iff (SRST) (w4 == 16'h0000) |-> WRITE_BYTES == 17'h10000;
	endproperty
	a_count: assert property (p_count) else $error("zero count wrong");

	property p_swap;
		@(posedge MCLK) disable iff (SRST) (FETCH_VALID && hdr[`TCI_HDR_SWAP] && $stable(hdr))
			|=> WDATA == {$past(FETCH_DATA[7:0]), $past(FETCH_DATA[15:8])};
	endproperty
	a_swap: assert property (p_swap) else $error("byte order wrong");

	property p_addr;
		@(posedge MCLK) disable iff (SRST) (FETCH.req && !ADDR22_EN) |-> FETCH.addr[21:18] == 4'h0;
	endproperty
	a_addr: assert property (p_addr) else $error("upper address used");

	property p_attention_message_off;
		@(posedge MCLK) disable iff (SRST) (ATTENTION_MESSAGE_EVENT && !char_mode[`TCI_CH_ATTENTION_MESSAGE]) |=> reject_next;
	endproperty
	a_attention_message_off: assert property (p_attention_message_off) else $error("attention not latched");
endmodule

// File: verification/tci_drive_model.sv
// Behavioural tape drive sequencer answering motion requests
// Assumes one motion request at a time, start level latched during reset
`timescale 1ns/100ps
module tci_drive_model
	import tci_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 srst,
	input  wire tci_pkg::tci_motion_s motion,
	input  wire logic                 start_in,
	input  wire logic                 end_in,
	input  wire logic                 rev_to_start,
	input  wire logic [7:0]           marks,
	input  wire logic [7:0]           wait_n,
	output tci_pkg::tci_drive_s       drive
);
	logic [7:0] cnt;
	logic [2:0] idx;
	logic       busy;
	logic       rev;
	logic       rew;
	logic       tog;
	// Record and mark toggle outside done so stale values never look valid
	always_ff @(posedge clk) begin
		tog          <= ~tog;
		drive.done   <= 1'b0;
		drive.record <= tog;
		drive.mark   <= ~tog;
		drive.at_end <= end_in;
		if (srst) begin
			tog            <= 1'b0;
			busy           <= 1'b0;
			idx            <= 3'h0;
			drive.at_start <= start_in;
		end else if (motion.go) begin
			busy <= 1'b1;
			cnt  <= wait_n;
			rev  <= (motion.op == TCI_MV_SPACE_REV);
			rew  <= (motion.op == TCI_MV_REWIND);
		end else if (busy && cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
		end else if (busy) begin
			busy       <= 1'b0;
			drive.done <= 1'b1;
			idx        <= idx + 3'h1;
			if (rew || (rev && rev_to_start)) begin
				drive.at_start <= 1'b1;
				drive.record   <= 1'b0;
				drive.mark     <= 1'b0;
			end else begin
				drive.at_start <= rev & drive.at_start;
				drive.record   <= ~marks[idx];
				drive.mark     <= marks[idx];
			end
		end
	end
endmodule

// File: verification/tci_top_test.sv
// Self-checking bench for the tape command interpreter
// Assumes the drive model stands in for the tape sequencer
`timescale 1ns/100ps
module tci_top_test;
	import tci_pkg::*;
	typedef struct packed {
		logic [7:0]  ch;
		logic [15:0] hdr;
		logic [15:0] w2;
		logic [2:0]  lv;
		logic [7:0]  mk;
		logic [2:0]  tc;
		logic [15:0] x0;
		logic [15:0] x3;
	} tci_row_s;
	logic        clk, srst, wr, rd, a22, attention_message, identification_burst, fv, st, en, rts, wv, am, irq;
	logic [3:0]  addr;
	logic [15:0] wd, rdat, fd, wdat, erm, v, last_wd;
	logic [16:0] wb;
	logic [21:0] last_fa;
	logic [7:0]  mk, wn;
	logic [8:0]  ops;
	tci_motion_s mo;
	tci_drive_s  dr;
	tci_fetch_s  fe;
	int          num_errors, checks, n_irq, n_attention_message;
	tci_row_s    rows [15];
	tci_top dut (.MCLK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
		.REG_RDATA(rdat), .ADDR22_EN(a22), .ATTENTION_MESSAGE_EVENT(attention_message), .ID_BURST_BAD(identification_burst), .DRIVE(dr), .MOTION(mo),
		.ERASE_MILS(erm), .FETCH(fe), .FETCH_VALID(fv), .FETCH_DATA(fd), .WDATA_VALID(wv), .WDATA(wdat),
		.WRITE_BYTES(wb), .ATTENTION_MESSAGE_MSG(am), .IRQ(irq));
	tci_drive_model model (.clk(clk), .srst(srst), .motion(mo), .start_in(st), .end_in(en),
		.rev_to_start(rts), .marks(mk), .wait_n(wn), .drive(dr));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Memory answers each fetch with one word in the next cycle
	always @(posedge clk) begin
		fv <= (fe.req === 1'b1);
		if (irq === 1'b1) n_irq <= n_irq + 1;
		if (am === 1'b1) n_attention_message <= n_attention_message + 1;
		if (fe.req === 1'b1) last_fa <= fe.addr;
		if (wv === 1'b1) last_wd <= wdat;
		if (mo.go === 1'b1) ops <= {ops[5:0], mo.op};
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdat;
	endtask
	task automatic rst(input logic s, input logic e, input logic b);
		@(posedge clk);
		st <= s;
		en <= e;
		identification_burst <= b;
		srst <= 1'b1;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		n_irq = 0;
		n_attention_message = 0;
	endtask
	task automatic load(input logic [7:0] c, input logic [15:0] h, w2, w3, w4);
		wr_reg(4'hc, 16'h000e);
		wr_reg(4'h0, {8'h00, c});
		wr_reg(4'h1, h);
		wr_reg(4'h2, w2);
		wr_reg(4'h3, w3);
		wr_reg(4'h4, w4);
		wr_reg(4'h5, 16'h0001);
	endtask
	task automatic wait_rdy();
		for (int i = 0; i < 500; i++) begin
			rd_reg(4'h6, v);
			if (v[7] === 1'b1) return;
		end
		num_errors++;
		stop_test();
	endtask
	task automatic pulse_attention_message();
		@(posedge clk);
		attention_message <= 1'b1;
		@(posedge clk);
		attention_message <= 1'b0;
	endtask
	initial begin
		{srst, wr, rd, addr, wd, a22, attention_message, identification_burst, st, en, rts, mk} = {1'b1, 28'h0, 8'h00};
		fd = 16'h12ab;
		wn = 8'd4;
		ops = 9'h0;
		rows = '{'{8'h00, 16'h0005, 16'h0, 3'b010, 8'h00, 3'h2, 16'h0001, 16'h0},
			'{8'h00, 16'h0009, 16'h0, 3'b010, 8'h00, 3'h2, 16'h0001, 16'h0},
			'{8'h00, 16'h0005, 16'h0, 3'b001, 8'h00, 3'h6, 16'h0000, 16'h8},
			'{8'h00, 16'h0109, 16'h0, 3'b001, 8'h00, 3'h6, 16'h0000, 16'h8},
			'{8'h00, 16'h0108, 16'h1, 3'b100, 8'h00, 3'h3, 16'h0400, 16'h0},
			'{8'h00, 16'h0308, 16'h1, 3'b100, 8'h00, 3'h3, 16'h0400, 16'h0},
			'{8'h00, 16'h0209, 16'h0, 3'b100, 8'h00, 3'h3, 16'h0400, 16'h0},
			'{8'h00, 16'h0008, 16'h1, 3'b001, 8'h00, 3'h2, 16'h0000, 16'h8},
			'{8'h00, 16'h0008, 16'h2, 3'b000, 8'h00, 3'h0, 16'h0000, 16'h0},
			'{8'h00, 16'h0008, 16'h2, 3'b000, 8'h01, 3'h2, 16'h4000, 16'h0},
			'{8'h80, 16'h0208, 16'h5, 3'b000, 8'h03, 3'h7, 16'h4000, 16'h0},
			'{8'hc0, 16'h0208, 16'h3, 3'b100, 8'h01, 3'h7, 16'h6000, 16'h0},
			'{8'h80, 16'h0208, 16'h2, 3'b100, 8'h05, 3'h0, 16'h0000, 16'h0},
			'{8'h00, 16'h0109, 16'h0, 3'b000, 8'h00, 3'h0, 16'h0000, 16'h0},
			'{8'h00, 16'h0308, 16'h1, 3'b000, 8'h01, 3'h0, 16'h0000, 16'h0}};
		rst(1'b0, 1'b0, 1'b0);
		rd_reg(4'h6, v);
		chk("status", 16'h0080, v);
		rd_reg(4'hd, v);
		chk("unmapped", 16'h0000, v);
		chk("erase_length", 16'd3750, erm);
		$display("reset test done");
		foreach (rows[i]) begin
			mk = rows[i].mk;
			rst(rows[i].lv[2], rows[i].lv[1], rows[i].lv[0]);
			load(rows[i].ch, rows[i].hdr, rows[i].w2, 16'h0, 16'h2);
			wait_rdy();
			if (rows[i].tc !== 3'h7) chk("term_class", rows[i].tc, v[2:0]);
			rd_reg(4'h7, v);
			chk("extended_status_0", rows[i].x0, v);
			rd_reg(4'h8, v);
			chk("extended_status_3", rows[i].x3, v);
			$display("row %0d done", i);
		end
		mk = 8'h00;
		for (int i = 0; i < 2; i++) begin
			a22 <= i[0];
			rst(1'b0, 1'b0, 1'b0);
			load(8'h00, {3'b000, i[0], 12'h005}, 16'h1000, 16'h003f, 16'h0000);
			wait_rdy();
			chk("fetch_addr", {(i[0] ? 4'hf : 4'h0), 2'b11, 16'h1000}, last_fa);
			chk("write_data", i[0] ? 16'hab12 : 16'h12ab, last_wd);
			chk("write_bytes", 17'h10000, wb);
			rst(1'b0, 1'b0, 1'b0);
			load(8'h00, i[0] ? 16'h0209 : 16'h0205, 16'h0, 16'h0, 16'h2);
			wait_rdy();
			chk("motion_order", {TCI_MV_SPACE_REV, TCI_MV_ERASE, i[0] ? TCI_MV_MARK : TCI_MV_WRITE}, ops);
		end
		$display("write test done");
		wn = 8'd60;
		rst(1'b0, 1'b0, 1'b0);
		load(8'h00, 16'h0488, 16'hffff, 16'h0, 16'h0);
		repeat (40) @(posedge clk);
		chk("irq", 0, n_irq);
		wait_rdy();
		chk("irq", 1, n_irq);
		chk("motion_op", TCI_MV_REWIND, ops[2:0]);
		$display("rewind test done");
		wn = 8'd4;
		rts = 1'b1;
		rst(1'b0, 1'b0, 1'b0);
		load(8'h00, 16'h0108, 16'h0003, 16'h0, 16'h0);
		wait_rdy();
		chk("term_class", 3'h2, v[2:0]);
		rd_reg(4'h8, v);
		chk("extended_status_3", 16'h0001, v);
		rd_reg(4'h9, v);
		chk("residual", 16'h0003, v);
		rts = 1'b0;
		$display("reverse test done");
		rst(1'b0, 1'b0, 1'b0);
		pulse_attention_message();
		load(8'h00, 16'h0008, 16'h0001, 16'h0, 16'h0);
		wait_rdy();
		chk("term_class", 3'h3, v[2:0]);
		chk("attention_message", 0, n_attention_message);
		rst(1'b0, 1'b0, 1'b0);
		load(8'h20, 16'h000a, 16'h0, 16'h0, 16'h0);
		wait_rdy();
		chk("irq", 0, n_irq);
		load(8'h30, 16'h000a, 16'h0, 16'h0, 16'h0);
		wait_rdy();
		chk("irq", 1, n_irq);
		pulse_attention_message();
		repeat (20) @(posedge clk);
		chk("attention_message", 1, n_attention_message);
		chk("irq", 1, n_irq);
		load(8'h30, 16'h008a, 16'h0, 16'h0, 16'h0);
		wait_rdy();
		pulse_attention_message();
		repeat (20) @(posedge clk);
		chk("attention_message", 2, n_attention_message);
		chk("irq", 3, n_irq);
		$display("attention test done");
		stop_test();
	end
endmodule
